// *** pkg/cioc_consts.vh ***
// Constants for the configurable I/O channel control block
`ifndef CIOC_CONSTS_VH
`define CIOC_CONSTS_VH
`define CIOC_FRAME_BITS        16
`define CIOC_FRAME_TYPE_BIT    15
`define CIOC_CHAN_MSB          14
`define CIOC_CHAN_LSB          12
`define CIOC_CODE_MSB          11
`define CIOC_REG_ADDR_MSB      14
`define CIOC_REG_ADDR_LSB      11
`define CIOC_GPIO_RB_BIT       10
`define CIOC_ADC_RANGE_BIT     5
`define CIOC_DAC_RANGE_BIT     4
`define CIOC_REG_LOAD_MODE     4'h7
`define CIOC_REG_ADC_SEQ       4'h2
`define CIOC_REG_GP_CTRL       4'h3
`define CIOC_REG_ADC_CFG       4'h4
`define CIOC_REG_DAC_CFG       4'h5
`define CIOC_REG_GPIO_WCFG     4'h8
`define CIOC_REG_GPIO_WDATA    4'h9
`define CIOC_REG_GPIO_RCFG     4'hA
`define CIOC_REG_BUSY_CFG      4'hB
`define CIOC_LOAD_DEFER_BIT    0
`define CIOC_LOAD_NOW_BIT      1
`define CIOC_CLK_MHZ           100
`define CIOC_CONV_TIME_NS      2000
`define CIOC_CONV_CYCLES       ((`CIOC_CONV_TIME_NS * `CIOC_CLK_MHZ) / 1000)
`endif

// *** verilog/cioc_sync.v ***
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module cioc_sync #(
  parameter W = 1
) (
  input  wire         i_sys_clk,
  input  wire         i_rst_n,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);
  reg [W-1:0] stage1;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stage1 <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // cioc_sync

// *** verilog/cioc_channel_ctrl.v ***
// Serial frame decoder, DAC loading, ADC sequencer and GPIO control
`timescale 1ns/1ps
`include "cioc_consts.vh"
module cioc_channel_ctrl #(
  parameter NCH         = 8,
  parameter CODE_W      = 12,
  parameter CONV_CYCLES = `CIOC_CONV_CYCLES
) (
  input  wire               i_sys_clk,
  input  wire               i_rst_n,
  input  wire               i_frame_select_n,
  input  wire               i_serial_clk,
  input  wire               i_serial_input_line,
  output reg                o_serial_output_line,
  input  wire [NCH-1:0]     i_configurable_channel_pin,
  output wire [NCH-1:0]     o_configurable_channel_pin,
  output wire [NCH-1:0]     o_configurable_channel_pin_oe_n,
  output reg  [NCH*CODE_W-1:0] o_dac_code,
  output reg  [NCH-1:0]     o_dac_enable,
  output reg                o_dac_gain2,
  output reg                o_adc_gain2,
  output reg  [NCH-1:0]     o_adc_mux_sel,
  output reg                o_adc_track,
  output reg                o_adc_start,
  input  wire               i_adc_done,
  input  wire [CODE_W-1:0]  i_adc_result,
  output wire               o_adc_busy
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_WAIT = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  wire [2:0]     link_s;
  wire [NCH-1:0] pin_s;
  // Select goes through inverted, so the synchroniser's zero reset reads as idle and no false fall follows reset
  cioc_sync #(.W(3)) u_link_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({~i_frame_select_n, i_serial_clk, i_serial_input_line}),
    .o_sync    (link_s)
  );
  cioc_sync #(.W(NCH)) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_configurable_channel_pin),
    .o_sync    (pin_s)
  );
  wire fs_n = ~link_s[2];
  wire sclk = link_s[1];
  wire serial_input_line  = link_s[0];
  reg  fs_n_d;
  reg  sclk_d;
  wire fs_fall   = fs_n_d & ~fs_n;
  wire fs_rise   = ~fs_n_d & fs_n;
  wire sclk_fall = sclk_d & ~sclk & ~fs_n;
  wire sclk_rise = ~sclk_d & sclk & ~fs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  reg [15:0]          shift_in;
  reg [4:0]           bit_cnt;
  reg [15:0]          shift_out;
  reg [NCH*CODE_W-1:0] dac_input;
  reg [NCH-1:0]       dac_cfg;
  reg [NCH-1:0]       adc_cfg;
  reg [NCH-1:0]       seq_mask;
  reg [NCH-1:0]       gpio_wcfg;
  reg [NCH-1:0]       gpio_wdata;
  reg [NCH-1:0]       gpio_rcfg;
  reg                 gpio_rb_pend;
  reg                 load_defer;
  reg                 busy_en;
  reg [2:0]           state;
  reg [15:0]          conv_cnt;
  reg [2:0]           cur_ch;
  reg [2:0]           conv_ch;
  reg [15:0]          result_frame;
  reg                 result_valid;
  reg                 seq_armed;
  reg                 busy;

  wire       frame_dac  = shift_in[`CIOC_FRAME_TYPE_BIT];
  wire [2:0] frame_ch   = shift_in[`CIOC_CHAN_MSB:`CIOC_CHAN_LSB];
  wire [3:0] frame_reg  = shift_in[`CIOC_REG_ADDR_MSB:`CIOC_REG_ADDR_LSB];
  wire [CODE_W-1:0] frame_code = shift_in[`CIOC_CODE_MSB:0];
  wire       cmd_go     = fs_rise & (bit_cnt == 5'd16);

  // Next selected channel above a start point, wrapping to the lowest
  function [2:0] next_sel;
    input [NCH-1:0] mask;
    input [2:0]     from;
    integer k;
    reg     found;
    reg [2:0] idx;
    begin
      next_sel = from;
      found = 1'b0;
      for (k = 1; k <= NCH; k = k + 1) begin
        idx = from + k[2:0];
        if (!found && mask[idx]) begin
          next_sel = idx;
          found = 1'b1;
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Serial shift and command decode
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fs_n_d <= 1'b1;
      sclk_d <= 1'b0;
      shift_in <= 16'h0000;
      bit_cnt <= 5'h00;
      dac_input <= {NCH*CODE_W{1'b0}};
      o_dac_code <= {NCH*CODE_W{1'b0}};
      dac_cfg <= {NCH{1'b0}};
      adc_cfg <= {NCH{1'b0}};
      seq_mask <= {NCH{1'b0}};
      gpio_wcfg <= {NCH{1'b0}};
      gpio_wdata <= {NCH{1'b0}};
      gpio_rcfg <= {NCH{1'b0}};
      gpio_rb_pend <= 1'b0;
      load_defer <= 1'b0;
      busy_en <= 1'b0;
      o_dac_gain2 <= 1'b0;
      o_adc_gain2 <= 1'b0;
      seq_armed <= 1'b0;
    end else begin
      fs_n_d <= fs_n;
      sclk_d <= sclk;
      if (fs_fall) begin
        bit_cnt <= 5'h00;
      end else if (sclk_fall && bit_cnt != 5'd16) begin
        shift_in <= {shift_in[14:0], serial_input_line};
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (fs_fall && gpio_rb_pend) begin
        gpio_rb_pend <= 1'b0;
      end
      if (fs_fall && seq_armed) begin
        seq_armed <= 1'b0;
      end
      if (cmd_go) begin
        if (frame_dac) begin
          dac_input[frame_ch*CODE_W +: CODE_W] <= frame_code;
          if (!load_defer) begin
            o_dac_code[frame_ch*CODE_W +: CODE_W] <= frame_code;
          end
        end else begin
          case (frame_reg)
            `CIOC_REG_LOAD_MODE: begin
              load_defer <= shift_in[`CIOC_LOAD_DEFER_BIT];
              if (shift_in[`CIOC_LOAD_NOW_BIT]) begin
                o_dac_code <= dac_input;
              end
            end
            `CIOC_REG_ADC_SEQ: begin
              seq_mask <= shift_in[NCH-1:0];
              seq_armed <= |shift_in[NCH-1:0];
            end
            `CIOC_REG_GP_CTRL: begin
              o_adc_gain2 <= shift_in[`CIOC_ADC_RANGE_BIT];
              o_dac_gain2 <= shift_in[`CIOC_DAC_RANGE_BIT];
            end
            `CIOC_REG_ADC_CFG: adc_cfg <= shift_in[NCH-1:0];
            `CIOC_REG_DAC_CFG: dac_cfg <= shift_in[NCH-1:0];
            `CIOC_REG_GPIO_WCFG: gpio_wcfg <= shift_in[NCH-1:0];
            `CIOC_REG_GPIO_WDATA: gpio_wdata <= shift_in[NCH-1:0];
            `CIOC_REG_GPIO_RCFG: begin
              gpio_rcfg <= shift_in[NCH-1:0];
              gpio_rb_pend <= shift_in[`CIOC_GPIO_RB_BIT];
            end
            `CIOC_REG_BUSY_CFG: busy_en <= shift_in[0];
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ADC sequencer; host keeps conversions 2 us apart and writes only when idle
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      conv_cnt <= 16'h0000;
      cur_ch <= 3'h0;
      conv_ch <= 3'h0;
      o_adc_mux_sel <= {NCH{1'b0}};
      o_adc_track <= 1'b0;
      o_adc_start <= 1'b0;
      result_frame <= 16'h0000;
      result_valid <= 1'b0;
      busy <= 1'b0;
    end else begin
      o_adc_start <= 1'b0;
      if (cmd_go && !frame_dac && frame_reg == `CIOC_REG_ADC_SEQ) begin
        cur_ch <= next_sel(shift_in[NCH-1:0], 3'h7);
        o_adc_mux_sel <= shift_in[NCH-1:0] & ~(shift_in[NCH-1:0] - 8'h01);
        o_adc_track <= |shift_in[NCH-1:0];
        result_valid <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (fs_fall && (seq_armed || result_valid) && |seq_mask) begin
            o_adc_start <= 1'b1;
            o_adc_track <= 1'b0;
            conv_ch <= cur_ch;
            busy <= 1'b1;
            conv_cnt <= 16'h0000;
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          conv_cnt <= conv_cnt + 16'h0001;
          if (i_adc_done || conv_cnt == CONV_CYCLES[15:0] - 16'h0001) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Straight binary result frame with zero marker
          result_frame <= {1'b0, conv_ch, i_adc_result};
          result_valid <= 1'b1;
          busy <= 1'b0;
          cur_ch <= next_sel(seq_mask, conv_ch);
          o_adc_mux_sel <= {{NCH-1{1'b0}}, 1'b1} << next_sel(seq_mask, conv_ch);
          o_adc_track <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial output: result of previous conversion or GPIO states
  wire [NCH-1:0] gpio_status = pin_s & gpio_rcfg;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      shift_out <= 16'h0000;
      o_serial_output_line <= 1'b0;
    end else if (fs_fall) begin
      if (gpio_rb_pend) begin
        shift_out <= {8'h00, gpio_status};
        o_serial_output_line <= 1'b0;
      end else if (result_valid) begin
        shift_out <= result_frame;
        o_serial_output_line <= result_frame[15];
      end else begin
        shift_out <= 16'h0000;
        o_serial_output_line <= 1'b0;
      end
    end else if (sclk_rise) begin
      o_serial_output_line <= shift_out[15];
    end else if (sclk_fall) begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive per channel
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_pin
      wire busy_pin = busy_en && (g == NCH - 1) && !o_dac_enable[g];
      assign o_configurable_channel_pin[g] = busy_pin ? ~busy : gpio_wdata[g];
      // DAC keeps the pin even when an ADC, GPIO or busy function is also set
      assign o_configurable_channel_pin_oe_n[g] = ~((gpio_wcfg[g] & ~o_dac_enable[g]) | busy_pin);
    end
  endgenerate
  // Drive follows the registered enable, so digital drive and DAC never overlap for a cycle
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_dac_enable <= {NCH{1'b0}};
    end else begin
      o_dac_enable <= dac_cfg;
    end
  end
  assign o_adc_busy = busy;
endmodule // cioc_channel_ctrl

// *** verif/cioc_channel_ctrl_props.sv ***
// Concurrent checks on the channel control ports
`timescale 1ns/1ps
module cioc_props #(
  parameter NCH         = 8,
  parameter CODE_W      = 12,
  parameter CONV_CYCLES = 200
) (
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst_n,
  input wire logic                    i_frame_select_n,
  input wire logic [NCH-1:0]          o_configurable_channel_pin_oe_n,
  input wire logic [NCH*CODE_W-1:0]   o_dac_code,
  input wire logic [NCH-1:0]          o_dac_enable,
  input wire logic [NCH-1:0]          o_adc_mux_sel,
  input wire logic                    o_adc_start,
  input wire logic                    o_adc_track,
  input wire logic                    o_adc_busy
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // Busy length counted here, too long for a repetition
  int bcnt;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) bcnt <= 0;
    else bcnt <= o_adc_busy ? bcnt + 1 : 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_conv;
    o_adc_start ##1 (o_adc_busy && !o_adc_track);
  endsequence
  property p_start_in_frame; o_adc_start |-> !i_frame_select_n; endproperty
  a_start_in_frame: assert property (p_start_in_frame) else $error("start outside frame");
  property p_start_busy; o_adc_start |-> s_conv; endproperty
  a_start_busy: assert property (p_start_busy) else $error("no busy after start");
  property p_conv_len; $fell(o_adc_busy) |-> bcnt == CONV_CYCLES + 1; endproperty
  a_conv_len: assert property (p_conv_len) else $error("busy length wrong");
  property p_track_hold; o_adc_busy |-> !o_adc_track; endproperty
  a_track_hold: assert property (p_track_hold) else $error("tracking while busy");
  property p_mux_onehot; $onehot0(o_adc_mux_sel); endproperty
  a_mux_onehot: assert property (p_mux_onehot) else $error("mux not one-hot");
  property p_mux_stable; $changed(o_adc_mux_sel) |-> !o_adc_busy; endproperty
  a_mux_stable: assert property (p_mux_stable) else $error("mux moved in conversion");
  property p_dac_drives; (~o_configurable_channel_pin_oe_n & o_dac_enable) == '0; endproperty
  a_dac_drives: assert property (p_dac_drives) else $error("digital drive on DAC pin");
  property p_regs_at_rise; $changed(o_dac_code) |-> i_frame_select_n; endproperty
  a_regs_at_rise: assert property (p_regs_at_rise) else $error("code changed in frame");
endmodule // cioc_props

bind cioc_channel_ctrl cioc_props #(.NCH(NCH), .CODE_W(CODE_W), .CONV_CYCLES(CONV_CYCLES)) i_cioc_props (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_frame_select_n(i_frame_select_n),
  .o_configurable_channel_pin_oe_n(o_configurable_channel_pin_oe_n), .o_dac_code(o_dac_code),
  .o_dac_enable(o_dac_enable), .o_adc_mux_sel(o_adc_mux_sel), .o_adc_start(o_adc_start),
  .o_adc_track(o_adc_track), .o_adc_busy(o_adc_busy));

// *** verif/cioc_host_model.sv ***
// Serial host model: frame select, serial clock and data lines
`timescale 1ns/1ps
module cioc_host_model (
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_sdi,
  input  wire  i_sdo
);
  initial begin
    o_sel_n = 1'b1;
    o_sclk  = 1'b1;
    o_sdi   = 1'b0;
  end
  // Clock idles high and stands still between frames
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = 16'h0000;
    o_sel_n = 1'b0;
    #100;
    for (int k = 0; k < n; k++) begin
      o_sdi = w[15-k];
      #40;
      o_sclk = 1'b0;
      #40;
      // Sampled late in the low phase, well clear of the device update
      r = {r[14:0], i_sdo};
      o_sclk = 1'b1;
    end
    #60;
    o_sel_n = 1'b1;
    o_sdi = ~o_sdi;
    #40;
  endtask
endmodule // cioc_host_model

// *** verif/tb_top.sv ***
// Self-checking bench for the channel control block
`timescale 1ns/1ps
module tb_top;
  localparam int CONV = 20;
  logic        clk, rst_n, sel_n, sclk, serial_input_line, serial_output_line, done, dg2, ag2, trk, start, busy;
  logic [7:0]  ext, pin_o, oe_n, pin_i, dac_en, mux, wd;
  logic [95:0] dac_code;
  logic [11:0] adc_val, code;
  logic [15:0] rd, exp_q[$];
  int          mismatches, compares, cyc, seed;
  assign pin_i = (~oe_n & pin_o) | (oe_n & ext);
  cioc_channel_ctrl #(.CONV_CYCLES(CONV)) i_cioc_channel_ctrl (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_frame_select_n(sel_n), .i_serial_clk(sclk), .i_serial_input_line(serial_input_line), .o_serial_output_line(serial_output_line),
    .i_configurable_channel_pin(pin_i), .o_configurable_channel_pin(pin_o),
    .o_configurable_channel_pin_oe_n(oe_n), .o_dac_code(dac_code), .o_dac_enable(dac_en),
    .o_dac_gain2(dg2), .o_adc_gain2(ag2), .o_adc_mux_sel(mux), .o_adc_track(trk), .o_adc_start(start),
    .i_adc_done(done), .i_adc_result(adc_val), .o_adc_busy(busy));
  cioc_host_model i_cioc_host_model (.o_sel_n(sel_n), .o_sclk(sclk), .o_sdi(serial_input_line), .i_sdo(serial_output_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    compares++;
    if (seen !== expv) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask
  task automatic finish_test;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] w, input int n = 16);
    @(posedge clk);
    #1;
    i_cioc_host_model.xfer(w, n, rd);
    repeat (10) @(posedge clk);
    #1;
  endtask
  function automatic logic [15:0] creg(input logic [3:0] a, input logic [10:0] d);
    return {1'b0, a, d};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Converter stand-in: fresh random result per conversion
  always @(posedge clk) begin
    if (start) begin
      #1 adc_val = 12'($random(seed));
      for (int c = 0; c < 8; c++)
        if (mux[c]) exp_q.push_back({1'b0, 3'(c), adc_val});
      repeat (3) @(posedge clk);
      check(16'({oe_n[7], pin_o[7]}), 16'h0000);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    seed = 17567;
    rst_n = 1'b0;
    ext = 8'h00;
    done = 1'b0;
    adc_val = 12'h000;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    check({oe_n, pin_o}, 16'hFF00);
    wr(creg(4'h5, 11'h0FF));
    check(16'(dac_en), 16'h00FF);
    for (int c = 0; c < 8; c++) begin
      code = (c == 0) ? 12'hFFF : (c == 1) ? 12'h000 : 12'($random(seed));
      wr({1'b1, 3'(c), code});
      check(16'(dac_code[c*12 +: 12]), 16'(code));
    end
    $display("end of dac load test");
    wr(creg(4'h7, 11'h001));
    wr(16'h95A5);
    check(16'(dac_code[23:12]), 16'h0000);
    wr(creg(4'h7, 11'h002));
    check(16'(dac_code[23:12]), 16'h05A5);
    wr(16'h9123, 15);
    check(16'(dac_code[23:12]), 16'h05A5);
    for (int g = 0; g < 4; g++) begin
      wr(creg(4'h3, 11'(g << 4)));
      check(16'({dg2, ag2}), 16'({g[0], g[1]}));
    end
    $display("end of load and range test");
    wd = 8'($random(seed));
    wr(creg(4'h5, 11'h00F));
    wr(creg(4'h8, 11'h030));
    wr(creg(4'h9, {3'h0, wd}));
    check({oe_n, pin_o & 8'h30}, {8'hCF, wd & 8'h30});
    ext = 8'($random(seed));
    wr(creg(4'hA, 11'h4F0));
    wr(16'h0000);
    check(rd, {8'h00, (ext & 8'hC0) | (wd & 8'h30)});
    $display("end of gpio test");
    wr(creg(4'hB, 11'h001));
    wr(creg(4'h4, 11'h091));
    wr(creg(4'h2, 11'h091));
    check(16'({trk, mux}), 16'h0101);
    repeat (60) @(posedge clk);
    for (int f = 0; f < 6; f++) begin
      wr(16'h0000);
      if (f > 0) check(rd, exp_q.pop_front());
      check(16'({oe_n[7], pin_o[7]}), 16'h0001);
      repeat (60) @(posedge clk);
    end
    $display("end of sequencer test");
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    check({oe_n, 8'(dac_code)}, 16'hFF00);
    $display("end of reset test");
    finish_test();
  end
endmodule // tb_top
